/* src/wiper_port_pkg.sv */
// Constants for the serial wiper control port
package wiper_port_pkg;
    localparam int unsigned instr_code_w = 3;
    localparam int unsigned reg_addr_w = 5;
    localparam int unsigned data_w = 8;
    localparam int unsigned bit_cnt_w = 3;
    localparam logic [4:0] addr_wiper = 5'h0_0;
    localparam logic [4:0] addr_access_ctl = 5'h1_0;
    localparam logic [2:0] instr_read = 3'h4;
    localparam logic [2:0] instr_write = 3'h6;
    localparam int unsigned vol_bit = 7;
    localparam int unsigned shdn_bit = 6;
    localparam int unsigned wip_bit = 5;
    localparam int unsigned out_type_bit = 1;
    localparam logic [7:0] wiper_reset_val = 8'h8_0;
    localparam logic [7:0] ivr_reset_val = 8'h8_0;
    localparam logic [7:0] acr_reset_val = 8'h4_0;
    localparam logic [7:0] wiper_top = 8'hF_F;
    localparam logic [7:0] wiper_bottom = 8'h0_0;
    localparam int unsigned clk_mhz = 100;
    localparam int unsigned nv_write_cycle_time_ms = 20;
    localparam int unsigned nv_write_cycles = nv_write_cycle_time_ms * 1000 * clk_mhz;
    localparam logic [2:0] last_bit = 3'h7;
endpackage

/* src/wiper_nv_timer.sv */
// Self-timed non-volatile write cycle timer
`timescale 1ns/1ps
module wiper_nv_timer #(
    parameter int unsigned cycles = wiper_port_pkg::nv_write_cycles
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // Control
    input wire logic start_in,
    output logic busy_out
);
    import wiper_port_pkg::*;
    logic [31:0] count_reg;
    wire done = busy_out && (count_reg == 32'h0000_0001);

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            count_reg <= 32'h0000_0000;
            busy_out <= 1'b0;
        end else if (start_in) begin
            count_reg <= cycles;
            busy_out <= 1'b1;
        end else if (busy_out) begin
            count_reg <= count_reg - 32'h0000_0001;
            busy_out <= !done;
        end
    end

    chk_busy_clears_done: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        done && !start_in |=> !busy_out) else $error("write cycle did not end");
endmodule

/* src/spi_slave_wiper_port.sv */
// Serial slave port of a digital potentiometer with wiper and control registers
// Summary of operation
// - Serial output changes on falling clock edges during reads.
// - Access control bit 1 selects push-pull or open-drain output.
// - Output type defaults to push-pull after reset.
// - Input bits captured on rising clock edges only while select low.
// - Select high deselects and floats serial output.
// - Deselected device goes standby unless a write cycle is running.
// - Select low enables device in active power mode.
// - Wiper value 255 nearest high terminal, 0 nearest low terminal.
// - Tap position follows wiper register directly.
// - Non-volatile write is self-timed, starting when the write sequence ends.
// - First byte: three-bit instruction code then five-bit register address.
// - Bytes travel most significant bit first both ways.
// - Write instructions execute on the rising select edge ending the transfer.
// - Address 10000 targets access control, zero targets wiper or initial value.
`timescale 1ns/1ps
module spi_slave_wiper_port
    import wiper_port_pkg::*;
#(
    parameter int unsigned nv_cycles = wiper_port_pkg::nv_write_cycles
) (
    // System clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // Serial link
    input wire logic sck_in,
    input wire logic cs_b_in,
    input wire logic sdi_in,
    output logic sdo_out,
    output logic sdo_oe_out,
    // Potentiometer state
    output logic [7:0] tap_sel_out,
    output logic at_high_terminal_out,
    output logic at_low_terminal_out,
    output logic shutdown_out,
    output logic active_out,
    output logic standby_out,
    output logic nv_busy_out
);
    import wiper_port_pkg::*;

    // Link-clock domain: shift in
    logic [7:0] shift_reg;
    logic [7:0] instr_reg;
    logic [7:0] data_reg;
    logic [2:0] bit_cnt_reg;
    logic byte_cnt_reg;
    logic got_data_reg;
    logic frame_tog_reg;
    logic [7:0] tx_reg;
    logic sdo_bit_reg;
    wire [7:0] shift_next = {shift_reg[6:0], sdi_in};
    wire byte_done = (bit_cnt_reg == last_bit);

    // counters held clear while select is high
    always_ff @(posedge sck_in or posedge cs_b_in) begin
        if (cs_b_in) begin
            bit_cnt_reg <= 3'h0;
            byte_cnt_reg <= 1'b0;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (byte_done) begin
                byte_cnt_reg <= 1'b1;
            end
        end
    end

    // Frame marker and data flag kept past select rise
    wire frame_first_bit = (bit_cnt_reg == 3'h0) && !byte_cnt_reg;
    always_ff @(posedge sck_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            got_data_reg <= 1'b0;
            frame_tog_reg <= 1'b0;
        end else if (!cs_b_in) begin
            if (frame_first_bit) begin
                got_data_reg <= 1'b0;
                frame_tog_reg <= !frame_tog_reg;
            end else if (byte_done && byte_cnt_reg) begin
                got_data_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge sck_in) begin
        if (!cs_b_in) begin
            shift_reg <= shift_next;
            if (byte_done && !byte_cnt_reg) begin
                instr_reg <= shift_next;
            end
            if (byte_done && byte_cnt_reg) begin
                data_reg <= shift_next;
            end
        end
    end

    // System domain: synchronise select and detect rising edge
    logic [2:0] cs_sync_reg;
    logic armed_reg;
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cs_sync_reg <= 3'b111;
        end else begin
            cs_sync_reg <= {cs_sync_reg[1:0], cs_b_in};
        end
    end
    wire cs_rise = cs_sync_reg[1] && !cs_sync_reg[2];
    wire cs_fall = !cs_sync_reg[1] && cs_sync_reg[2];

    // no operation accepted before first select fall
    logic frame_seen_reg;
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            armed_reg <= 1'b0;
            frame_seen_reg <= 1'b0;
        end else begin
            if (cs_fall) begin
                armed_reg <= 1'b1;
            end
            if (cs_rise) begin
                frame_seen_reg <= frame_tog_reg;
            end
        end
    end

    // Registers and execution
    logic [7:0] wiper_reg;
    logic [7:0] ivr_reg;
    logic [7:0] acr_reg;
    logic nv_start_reg;
    logic wip_view_reg;
    wire nv_busy;
    wire [2:0] op_code = instr_reg[7:5];
    wire [4:0] op_addr = instr_reg[4:0];
    wire hit_wiper = (op_addr == addr_wiper);
    wire hit_acr = (op_addr == addr_access_ctl);
    wire frame_new = (frame_tog_reg != frame_seen_reg);
    wire exec_write = cs_rise && armed_reg && frame_new && got_data_reg && (op_code == instr_write);
    wire acr_vol = acr_reg[vol_bit];
    wire [7:0] acr_view = {acr_reg[7:6], wip_view_reg, 3'h0, acr_reg[out_type_bit], 1'b0};
    wire [7:0] rd_value = (op_code != instr_read) ? 8'h0_0 :
                          (op_addr == addr_access_ctl) ? acr_view :
                          (op_addr != addr_wiper) ? 8'h0_0 :
                          acr_vol ? wiper_reg : ivr_reg;

    // Busy bit frozen while selected for the link side
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wip_view_reg <= 1'b0;
        end else if (cs_sync_reg[1]) begin
            wip_view_reg <= nv_busy;
        end
    end

    // Read data launched on falling edges
    always_ff @(negedge sck_in or posedge cs_b_in) begin
        if (cs_b_in) begin
            sdo_bit_reg <= 1'b0;
            tx_reg <= 8'h0_0;
        end else if (byte_cnt_reg && bit_cnt_reg == 3'h0 && !got_data_reg) begin
            sdo_bit_reg <= rd_value[7];
            tx_reg <= {rd_value[6:0], 1'b0};
        end else begin
            sdo_bit_reg <= tx_reg[7];
            tx_reg <= {tx_reg[6:0], 1'b0};
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wiper_reg <= wiper_reset_val;
            ivr_reg <= ivr_reset_val;
            acr_reg <= acr_reset_val;
            nv_start_reg <= 1'b0;
        end else begin
            nv_start_reg <= 1'b0;
            if (exec_write && hit_acr && !nv_busy) begin
                acr_reg <= {data_reg[7:6], 4'h0, data_reg[out_type_bit], 1'b0};
            end
            if (exec_write && hit_wiper && !nv_busy) begin
                wiper_reg <= data_reg;
                if (!acr_vol) begin
                    ivr_reg <= data_reg;
                    nv_start_reg <= 1'b1;
                end
            end
        end
    end

    wiper_nv_timer #(.cycles(nv_cycles)) nv_timer (
        .mclk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .start_in(nv_start_reg),
        .busy_out(nv_busy)
    );

    // Pin drive and status
    wire open_drain = acr_reg[out_type_bit];
    wire selected = !cs_b_in;
    assign sdo_out = open_drain ? 1'b0 : sdo_bit_reg;
    assign sdo_oe_out = selected && (!open_drain || !sdo_bit_reg);
    assign tap_sel_out = wiper_reg;
    assign at_high_terminal_out = (wiper_reg == wiper_top);
    assign at_low_terminal_out = (wiper_reg == wiper_bottom);
    assign shutdown_out = !acr_reg[shdn_bit];
    assign active_out = !cs_sync_reg[1] || nv_busy;
    assign standby_out = !active_out;
    assign nv_busy_out = nv_busy;

    chk_deselect_float: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        cs_b_in |-> !sdo_oe_out) else $error("output driven while deselected");
    chk_od_drive_low: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        open_drain && sdo_oe_out |-> !sdo_out) else $error("open drain drove high");
    chk_standby_busy: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        nv_busy |-> !standby_out) else $error("standby during write cycle");
    chk_active_select: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        !cs_sync_reg[1] |-> active_out) else $error("not active while selected");
    chk_write_starts_nv: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        exec_write && hit_wiper && !acr_vol && !nv_busy |=> nv_start_reg ##1 nv_busy)
        else $error("nv cycle not started");
    chk_wiper_on_exec: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        $changed(wiper_reg) |-> $past(exec_write)) else $error("wiper moved without write");
    chk_no_op_unarmed: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        !armed_reg |=> $stable(acr_reg)) else $error("operation before select fall");
    chk_tap_follow: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        at_high_terminal_out |-> tap_sel_out == wiper_top) else $error("high tap wrong");
    cov_write: cover property (@(posedge mclk_in) exec_write && hit_wiper);
    cov_acr_write: cover property (@(posedge mclk_in) exec_write && hit_acr);
    cov_nv_done: cover property (@(posedge mclk_in) $fell(nv_busy));
endmodule

/* tb/spi_host_model.sv */
// Host serial master model for the wiper port
`timescale 1ns/1ps
module spi_host_model (
    // Serial link
    output logic sck_out,
    output logic cs_b_out,
    output logic sdi_out,
    input wire logic sdo_in
);
    initial begin
        sck_out = 1'b0;
        cs_b_out = 1'b1;
        sdi_out = 1'b0;
    end
    // Mode 0 frame; clock stands low outside frames
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        #2000;
        cs_b_out = 1'b0;
        #250;
        for (int i = 15; i >= 0; i--) begin
            sdi_out = tx[i];
            #24 sck_out = 1'b1;
            rx[i] = sdo_in;
            #24 sck_out = 1'b0;
        end
        #250 cs_b_out = 1'b1;
        sdi_out = ~sdi_out;
    endtask
    // Clock pulses with select high, to be ignored by the slave
    task automatic idle_clocks(input int n);
        for (int i = 0; i < n; i++) begin
            sdi_out = 1'b1;
            #24 sck_out = 1'b1;
            #24 sck_out = 1'b0;
        end
    endtask
endmodule

/* tb/tb.sv */
// Self-checking bench for the serial wiper port
`timescale 1ns/1ps
`define check(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module tb;
    import wiper_port_pkg::*;
    logic mclk_in, rst_b_in, sck, cs_b, sdi, sdo_out, sdo_oe_out, sdo_pin;
    logic [7:0] tap_sel_out;
    logic at_high_terminal_out, at_low_terminal_out, shutdown_out, active_out, standby_out, nv_busy_out;
    logic [15:0] rx;
    int miscompares = 0;
    int comparisons = 0;
    // Board pull-up on the serial output
    assign sdo_pin = sdo_oe_out ? sdo_out : 1'b1;
    spi_slave_wiper_port #(.nv_cycles(50)) spi_slave_wiper_port_i (
        .mclk_in(mclk_in), .rst_b_in(rst_b_in), .sck_in(sck), .cs_b_in(cs_b), .sdi_in(sdi),
        .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out), .tap_sel_out(tap_sel_out),
        .at_high_terminal_out(at_high_terminal_out), .at_low_terminal_out(at_low_terminal_out),
        .shutdown_out(shutdown_out), .active_out(active_out), .standby_out(standby_out),
        .nv_busy_out(nv_busy_out));
    spi_host_model spi_host_model_i (.sck_out(sck), .cs_b_out(cs_b), .sdi_out(sdi), .sdo_in(sdo_pin));
    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end
    task automatic results;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // One frame, then time for the select-rise execution
    task automatic frame(input logic [15:0] tx);
        spi_host_model_i.xfer(tx, rx);
        repeat (8) @(negedge mclk_in);
    endtask
    task automatic reset_values;
        `check(tap_sel_out, 8'h80)
        `check(standby_out, 1'b1)
        `check(sdo_oe_out, 1'b0)
        `check(nv_busy_out, 1'b0)
    endtask
    task automatic volatile_write;
        frame(16'hD080);
        `check(shutdown_out, 1'b1)
        frame(16'hD0C0);
        `check(shutdown_out, 1'b0)
        frame(16'hC0FF);
        `check(tap_sel_out, 8'hFF)
        `check(at_high_terminal_out, 1'b1)
        frame(16'hC000);
        `check(tap_sel_out, 8'h00)
        `check(at_low_terminal_out, 1'b1)
    endtask
    task automatic stray_clocks;
        spi_host_model_i.idle_clocks(5);
        frame(16'hC0A5);
        `check(tap_sel_out, 8'hA5)
        spi_host_model_i.idle_clocks(3);
        frame(16'h9000);
        `check(rx[7:0], 8'hC0)
    endtask
    task automatic mid_reset;
        @(negedge mclk_in);
        rst_b_in = 1'b0;
        repeat (4) @(negedge mclk_in);
        rst_b_in = 1'b1;
        @(negedge mclk_in);
        `check(tap_sel_out, wiper_reset_val)
        frame(16'h9000);
        `check(rx[7:0], acr_reset_val)
    endtask
    task automatic read_acr;
        frame(16'h9000);
        `check(rx[7:0], 8'hC0)
        `check(sdo_oe_out, 1'b0)
    endtask
    task automatic open_drain;
        frame(16'hD0C2);
        frame(16'h9000);
        `check(rx[7:0], 8'hC2)
        frame(16'hD0C0);
        frame(16'h9000);
        `check(rx[7:0], 8'hC0)
    endtask
    task automatic nv_write;
        int n;
        frame(16'hD040);
        spi_host_model_i.xfer(16'hC033, rx);
        repeat (8) @(negedge mclk_in);
        `check(tap_sel_out, 8'h33)
        `check(nv_busy_out, 1'b1)
        `check(active_out, 1'b1)
        n = 0;
        while (nv_busy_out !== 1'b0 && n < 200) begin
            @(negedge mclk_in);
            n++;
        end
        if (n >= 200) begin
            miscompares++;
            results();
        end
        repeat (4) @(negedge mclk_in);
        `check(standby_out, 1'b1)
        frame(16'h8000);
        `check(rx[7:0], 8'h33)
    endtask
    initial begin
        rst_b_in = 1'b0;
        repeat (12) @(negedge mclk_in);
        rst_b_in = 1'b1;
        @(negedge mclk_in);
        reset_values();
        volatile_write();
        stray_clocks();
        read_acr();
        open_drain();
        nv_write();
        mid_reset();
        results();
    end
endmodule
